// file: hdl/ppl_cfg.svh
// register offsets, reset values and timing counts for the parallel port latches
`ifndef PPL_CFG_SVH
`define PPL_CFG_SVH
`define PPL_OFF_LOW_LAT 8'h00
`define PPL_OFF_MIX_LAT 8'h04
`define PPL_OFF_HI_LAT 8'h08
`define PPL_OFF_LOW_PIN 8'h0c
`define PPL_OFF_MIX_PIN 8'h10
`define PPL_OFF_HI_PIN 8'h14
`define PPL_OFF_CTRL 8'h18
`define PPL_CTRL_ROUTE_BIT 0
`define PPL_LAT_RESET 8'hff
`define PPL_CLK_PERIOD_NS 40
`define PPL_OSC_PERIOD_NS 40
`define PPL_STRONG_PERIODS 2
`define PPL_STRONG_CYC ((`PPL_STRONG_PERIODS*`PPL_OSC_PERIOD_NS+`PPL_CLK_PERIOD_NS-1)/`PPL_CLK_PERIOD_NS)
`endif

// file: hdl/ppl_pkg.sv
// types shared by the parallel port latch block
package ppl_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ppl_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ppl_apb_rsp_t;
  // external memory controller side, same clock
  typedef struct packed {
    logic active;
    logic [7:0] ad_out;
    logic ad_oe;
    logic hi_en;
    logic [7:0] addr_hi;
  } ppl_xmem_t;
  typedef struct packed {
    logic [7:0] lo_out;
    logic [7:0] lo_oe;
    logic [7:0] mx_out;
    logic [7:0] mx_oe;
    logic [7:0] hi_out;
    logic [7:0] hi_oe;
  } ppl_pin_drv_t;
  // index 1:0 are mixed bits 1:0, index 9:2 are high port bits 7:0
  typedef struct packed {
    logic [9:0] strong_pullup;
    logic [9:0] keeper_pullup;
    logic [9:0] very_weak_pullup;
  } ppl_pullup_t;
  typedef struct packed {
    logic [7:0] low_port_latch;
    logic [7:0] mixed_port_latch;
    logic [7:0] high_port_latch;
    logic pwm_route;
    logic [9:0] pu_prev;
    logic [9:0][1:0] str_cnt;
    logic [23:0] sync1;
    logic [23:0] sync2;
    ppl_apb_rsp_t rsp;
    ppl_pin_drv_t drv;
    ppl_pullup_t pu;
    logic timer_two_count_input;
    logic timer_two_trigger_input;
    logic [5:0] analog_sel;
  } ppl_state_t;
endpackage

// file: hdl/ppl_port_latches.sv
// three parallel ports: latches, pin reads, drivers and active pull-up control
//
// Behaviour
// - each pin has a latch bit loaded from the bus on a write strobe
// - read-latch returns stored latch; read-pin returns the sensed pin level
// - low port is 8-bit open-drain, also muxed address/data for external memory
// - any external memory access forces all low port latches to one
// - during external access low port drives address/data push-pull
// - low port general mode: latch one floats, latch zero drives low
// - mixed bits 0,1 pulled up when latch one, driven low when zero
// - timer-two inputs on mixed bits 0,1 work only while latch is one
// - routed pwm outputs override mixed bit 0,1 latch contents
// - bit0 carries timer count input or pwm a; bit1 trigger or pwm b
// - latch zero-to-one enables strong pull-up two oscillator periods, then keeper
// - pin pulled low externally turns keeper off; very weak pull-up remains
// - mixed bits 2-7 are inputs only; latch one selects analog, zero digital
// - mixed bits 2-7 never drive their pins
// - high port outputs upper address bytes during external accesses
// - external addressing drives high port push-pull; its latch stays unchanged
// - high port general mode: latch one pulled up, latch zero drives low
// - a pin given to an enabled peripheral is not general purpose io
// - read-modify-write reads of a port return the latch, not the pin
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "ppl_cfg.svh"
module ppl_port_latches #(
  parameter int STRONG_CYC = `PPL_STRONG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire ppl_pkg::ppl_apb_req_t apb_req,
  output ppl_pkg::ppl_apb_rsp_t apb_rsp,
  input wire ppl_pkg::ppl_xmem_t xmem,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic [7:0] lo_pin_i,
  input wire logic [7:0] mx_pin_i,
  input wire logic [7:0] hi_pin_i,
  output ppl_pkg::ppl_pin_drv_t pin_drv,
  output ppl_pkg::ppl_pullup_t pullups,
  output logic timer_two_count_input,
  output logic timer_two_trigger_input,
  output logic [5:0] analog_sel
);
  import ppl_pkg::*;

  ppl_state_t st_q;
  ppl_state_t st_d;
  logic acc;
  logic wr;
  logic [9:0] gp_hi;
  logic [9:0] pu_pin;

  function automatic logic [31:0] zx8(input logic [7:0] v);
    zx8 = {24'h000000, v};
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `PPL_OFF_LOW_LAT) || (a == `PPL_OFF_MIX_LAT) || (a == `PPL_OFF_HI_LAT) ||
               (a == `PPL_OFF_LOW_PIN) || (a == `PPL_OFF_MIX_PIN) || (a == `PPL_OFF_HI_PIN) ||
               (a == `PPL_OFF_CTRL);
  endfunction

  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & st_q.rsp.pready & apb_req.pwrite;
  // pins held high by the active pull-up; zero once a peripheral or address owns them
  assign gp_hi = {xmem.hi_en ? 8'h00 : st_q.high_port_latch,
                  st_q.pwm_route ? 2'b00 : st_q.mixed_port_latch[1:0]};
  // second sync stage only; the first stage feeds nothing but this stage
  assign pu_pin = {st_q.sync2[23:16], st_q.sync2[9:8]};

  always_comb begin
    st_d = st_q;
    st_d.sync1 = {hi_pin_i, mx_pin_i, lo_pin_i};
    st_d.sync2 = st_q.sync1;

    // apb: one wait state, answer registered
    st_d.rsp.pready = acc & ~st_q.rsp.pready;
    st_d.rsp.pslverr = 1'b0;
    if (acc & ~st_q.rsp.pready) begin
      st_d.rsp.pslverr = ~addr_hit(apb_req.paddr);
      case (apb_req.paddr)
        `PPL_OFF_LOW_LAT: st_d.rsp.prdata = zx8(st_q.low_port_latch);
        `PPL_OFF_MIX_LAT: st_d.rsp.prdata = zx8(st_q.mixed_port_latch);
        `PPL_OFF_HI_LAT: st_d.rsp.prdata = zx8(st_q.high_port_latch);
        `PPL_OFF_LOW_PIN: st_d.rsp.prdata = zx8(st_q.sync2[7:0]);
        `PPL_OFF_MIX_PIN: st_d.rsp.prdata = zx8(st_q.sync2[15:8]);
        `PPL_OFF_HI_PIN: st_d.rsp.prdata = zx8(st_q.sync2[23:16]);
        `PPL_OFF_CTRL: st_d.rsp.prdata = {30'h0, xmem.active, st_q.pwm_route};
        default: st_d.rsp.prdata = 32'h00000000;
      endcase
    end

    if (wr) begin
      case (apb_req.paddr)
        `PPL_OFF_LOW_LAT: st_d.low_port_latch = apb_req.pwdata[7:0];
        `PPL_OFF_MIX_LAT: st_d.mixed_port_latch = apb_req.pwdata[7:0];
        `PPL_OFF_HI_LAT: st_d.high_port_latch = apb_req.pwdata[7:0];
        `PPL_OFF_CTRL: st_d.pwm_route = apb_req.pwdata[`PPL_CTRL_ROUTE_BIT];
        default: st_d.pwm_route = st_q.pwm_route;
      endcase
    end
    // the memory access wins over a software write in the same cycle
    if (xmem.active) begin
      st_d.low_port_latch = `PPL_LAT_RESET;
    end

    // low port
    if (xmem.active) begin
      st_d.drv.lo_out = xmem.ad_out;
      st_d.drv.lo_oe = xmem.ad_oe ? 8'hff : 8'h00;
    end else begin
      st_d.drv.lo_out = 8'h00;
      st_d.drv.lo_oe = ~st_q.low_port_latch;
    end

    // mixed port: only bits 1:0 have drivers
    if (st_q.pwm_route) begin
      st_d.drv.mx_out = {6'h00, pwm_out_b, pwm_out_a};
      st_d.drv.mx_oe = 8'h03;
    end else begin
      st_d.drv.mx_out = 8'h00;
      st_d.drv.mx_oe = {6'h00, ~st_q.mixed_port_latch[1:0]};
    end
    st_d.analog_sel = st_q.mixed_port_latch[7:2];

    // timer inputs read the pin only while the latch releases it
    st_d.timer_two_count_input = st_q.mixed_port_latch[0] & ~st_q.pwm_route & st_q.sync2[8];
    st_d.timer_two_trigger_input = st_q.mixed_port_latch[1] & ~st_q.pwm_route & st_q.sync2[9];

    // high port
    if (xmem.hi_en) begin
      st_d.drv.hi_out = xmem.addr_hi;
      st_d.drv.hi_oe = 8'hff;
    end else begin
      st_d.drv.hi_out = 8'h00;
      st_d.drv.hi_oe = ~st_q.high_port_latch;
    end

    // active pull-ups on mixed bits 1:0 and the high port
    for (int i = 0; i < 10; i++) begin
      if (gp_hi[i] & ~st_q.pu_prev[i]) begin
        st_d.str_cnt[i] = 2'(STRONG_CYC);
      end else if (st_q.str_cnt[i] != 2'd0) begin
        st_d.str_cnt[i] = st_q.str_cnt[i] - 2'd1;
      end
      st_d.pu.strong_pullup[i] = st_d.str_cnt[i] != 2'd0;
      if (!gp_hi[i] || !pu_pin[i]) begin
        st_d.pu.keeper_pullup[i] = 1'b0;
      end else if (st_d.str_cnt[i] == 2'd0) begin
        st_d.pu.keeper_pullup[i] = 1'b1;
      end
      // very weak device keeps sourcing even while the keeper is off
      st_d.pu.very_weak_pullup[i] = gp_hi[i];
    end
    st_d.pu_prev = gp_hi;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.low_port_latch <= `PPL_LAT_RESET;
      st_q.mixed_port_latch <= `PPL_LAT_RESET;
      st_q.high_port_latch <= `PPL_LAT_RESET;
      st_q.pu_prev <= 10'h3ff;
      st_q.pu.very_weak_pullup <= 10'h3ff;
      st_q.analog_sel <= 6'h3f;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp = st_q.rsp;
  assign pin_drv = st_q.drv;
  assign pullups = st_q.pu;
  assign timer_two_count_input = st_q.timer_two_count_input;
  assign timer_two_trigger_input = st_q.timer_two_trigger_input;
  assign analog_sel = st_q.analog_sel;

  AST_LATCH_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr && apb_req.paddr == `PPL_OFF_HI_LAT |=> st_q.high_port_latch == $past(apb_req.pwdata[7:0]))
    else $error("high latch did not take written data");
  AST_READ_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !st_q.rsp.pready && apb_req.paddr == `PPL_OFF_LOW_PIN
    |=> apb_rsp.pready && apb_rsp.prdata == zx8($past(st_q.sync2[7:0])))
    else $error("pin read returned wrong value");
  AST_READ_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !st_q.rsp.pready && apb_req.paddr == `PPL_OFF_MIX_LAT
    |=> apb_rsp.prdata == zx8($past(st_q.mixed_port_latch)))
    else $error("latch read returned wrong value");
  AST_EXT_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    xmem.active |=> st_q.low_port_latch == 8'hff)
    else $error("low latches not forced to one");
  AST_LOW_PUSHPULL: assert property (@(posedge pclk) disable iff (!presetn)
    xmem.active && xmem.ad_oe |=> pin_drv.lo_out == $past(xmem.ad_out) && pin_drv.lo_oe == 8'hff)
    else $error("low port not driving address data");
  AST_LOW_OPEN_DRAIN: assert property (@(posedge pclk) disable iff (!presetn)
    !xmem.active |=> pin_drv.lo_oe == ~$past(st_q.low_port_latch) && pin_drv.lo_out == 8'h00)
    else $error("low port open-drain drive wrong");
  AST_NO_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drv.mx_oe[7:2] == 6'h00)
    else $error("input-only pin driven");
  AST_T2_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.mixed_port_latch[0] |=> !timer_two_count_input)
    else $error("timer input active with latch zero");
  AST_PWM_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.pwm_route |=> pin_drv.mx_out[1:0] == $past({pwm_out_b, pwm_out_a}) && pin_drv.mx_oe[1:0] == 2'b11)
    else $error("pwm did not override latch");
  AST_STRONG_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    gp_hi[2] && !st_q.pu_prev[2] |=> pullups.strong_pullup[2] [*2] ##1 !pullups.strong_pullup[2])
    else $error("strong pull-up pulse length wrong");
  AST_KEEPER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !pu_pin[0] |=> !pullups.keeper_pullup[0])
    else $error("keeper stayed on with pin low");
  AST_HI_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    xmem.hi_en && !wr |=> pin_drv.hi_out == $past(xmem.addr_hi) && pin_drv.hi_oe == 8'hff &&
    st_q.high_port_latch == $past(st_q.high_port_latch))
    else $error("high port address drive wrong");

  // bus handshake: one wait state, answer stands a single cycle
  AST_PREADY_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !apb_rsp.pready
    |=> apb_rsp.pready)
    else $error("pready missing after access");

  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    apb_rsp.pready
    |=> !apb_rsp.pready)
    else $error("pready held longer than one cycle");

  AST_NO_READY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !acc
    |=> !apb_rsp.pready)
    else $error("pready without access");

  AST_SLVERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !apb_rsp.pready && !addr_hit(apb_req.paddr)
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000)
    else $error("unmapped access not refused");

  AST_SLVERR_MAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !apb_rsp.pready && addr_hit(apb_req.paddr)
    |=> !apb_rsp.pslverr)
    else $error("mapped access refused");

  // read paths: latch addresses give the latch, pin addresses the synced pin
  AST_READ_LOW_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !st_q.rsp.pready && apb_req.paddr == `PPL_OFF_LOW_LAT
    |=> apb_rsp.prdata == zx8($past(st_q.low_port_latch)))
    else $error("low latch read wrong");

  AST_READ_HI_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !st_q.rsp.pready && apb_req.paddr == `PPL_OFF_HI_LAT
    |=> apb_rsp.prdata == zx8($past(st_q.high_port_latch)))
    else $error("high latch read wrong");

  AST_READ_MIX_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !st_q.rsp.pready && apb_req.paddr == `PPL_OFF_MIX_PIN
    |=> apb_rsp.prdata == zx8($past(st_q.sync2[15:8])))
    else $error("mixed pin read wrong");

  AST_READ_HI_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !st_q.rsp.pready && apb_req.paddr == `PPL_OFF_HI_PIN
    |=> apb_rsp.prdata == zx8($past(st_q.sync2[23:16])))
    else $error("high pin read wrong");

  // latch writes and holds
  AST_LOW_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr && apb_req.paddr == `PPL_OFF_LOW_LAT && !xmem.active
    |=> st_q.low_port_latch == $past(apb_req.pwdata[7:0]))
    else $error("low latch did not take written data");

  AST_MIX_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr && apb_req.paddr == `PPL_OFF_MIX_LAT
    |=> st_q.mixed_port_latch == $past(apb_req.pwdata[7:0]))
    else $error("mixed latch did not take written data");

  AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !wr && !xmem.active
    |=> st_q.low_port_latch == $past(st_q.low_port_latch) && st_q.mixed_port_latch == $past(st_q.mixed_port_latch) &&
    st_q.high_port_latch == $past(st_q.high_port_latch))
    else $error("latch changed without a write");

  AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr && apb_req.paddr == `PPL_OFF_CTRL
    |=> st_q.pwm_route == $past(apb_req.pwdata[`PPL_CTRL_ROUTE_BIT]))
    else $error("pwm route bit not written");

  AST_RESET_LATCHES: assert property (@(posedge pclk)
    $rose(presetn)
    |-> st_q.low_port_latch == `PPL_LAT_RESET && st_q.mixed_port_latch == `PPL_LAT_RESET &&
    st_q.high_port_latch == `PPL_LAT_RESET)
    else $error("latches not one after reset");

  AST_RESET_PINS: assert property (@(posedge pclk)
    $rose(presetn)
    |-> pin_drv.lo_oe == 8'h00 && pin_drv.mx_oe == 8'h00 && pin_drv.hi_oe == 8'h00)
    else $error("pin driven after reset");

  // low port released during the data phase of an access
  AST_LOW_FLOAT_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    xmem.active && !xmem.ad_oe
    |=> pin_drv.lo_oe == 8'h00)
    else $error("low port driven in data phase");

  // mixed port drivers and timer inputs
  AST_MX_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.pwm_route
    |=> pin_drv.mx_oe[1:0] == ~$past(st_q.mixed_port_latch[1:0]) && pin_drv.mx_out == 8'h00)
    else $error("mixed port general drive wrong");

  AST_NO_DRIVE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    pin_drv.mx_out[7:2] == 6'h00)
    else $error("input-only pin has drive value");

  AST_ANALOG_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> analog_sel == $past(st_q.mixed_port_latch[7:2]))
    else $error("analog select does not follow latch");

  AST_TIMER_TWO_TRIGGER_INPUT_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.mixed_port_latch[1]
    |=> !timer_two_trigger_input)
    else $error("trigger input active with latch zero");

  AST_PWM_TIMER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.pwm_route
    |=> !timer_two_count_input && !timer_two_trigger_input)
    else $error("timer inputs active while pwm owns pins");

  AST_T2_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.mixed_port_latch[0] && !st_q.pwm_route
    |=> timer_two_count_input == $past(st_q.sync2[8]))
    else $error("count input does not follow pin");

  AST_TIMER_TWO_TRIGGER_INPUT_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.mixed_port_latch[1] && !st_q.pwm_route
    |=> timer_two_trigger_input == $past(st_q.sync2[9]))
    else $error("trigger input does not follow pin");

  // high port general mode
  AST_HI_GENERAL: assert property (@(posedge pclk) disable iff (!presetn)
    !xmem.hi_en
    |=> pin_drv.hi_oe == ~$past(st_q.high_port_latch) && pin_drv.hi_out == 8'h00)
    else $error("high port general drive wrong");

  // active pull-up sequencing
  AST_STRONG_ONLY_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.str_cnt[0] == 2'd0 && !(gp_hi[0] && !st_q.pu_prev[0])
    |=> !pullups.strong_pullup[0])
    else $error("strong pull-up without a rising latch");

  AST_KEEPER_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    pullups.strong_pullup[0]
    |-> !pullups.keeper_pullup[0])
    else $error("keeper on during strong pulse");

  AST_KEEPER_ON: assert property (@(posedge pclk) disable iff (!presetn)
    gp_hi[0] && pu_pin[0] && st_q.pu_prev[0] && st_q.str_cnt[0] <= 2'd1
    |=> pullups.keeper_pullup[0])
    else $error("keeper not on after strong pulse");

  AST_WEAK_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> pullups.very_weak_pullup == $past(gp_hi))
    else $error("very weak pull-up wrong");

  AST_HI_KEEPER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !pu_pin[2]
    |=> !pullups.keeper_pullup[2])
    else $error("high port keeper stayed on with pin low");

  AST_PULLUP_OFF_DRIVEN: assert property (@(posedge pclk) disable iff (!presetn)
    !gp_hi[2]
    |=> !pullups.keeper_pullup[2] && !pullups.very_weak_pullup[2])
    else $error("pull-up on while pin driven or owned");

  COV_EXT_ACCESS: cover property (@(posedge pclk) disable iff (!presetn) xmem.active ##1 !xmem.active);
  COV_PWM_ROUTE: cover property (@(posedge pclk) disable iff (!presetn) st_q.pwm_route && pwm_out_a);
  COV_KEEPER_DROP: cover property (@(posedge pclk) disable iff (!presetn)
    pullups.keeper_pullup[2] ##1 !pullups.keeper_pullup[2] && gp_hi[2]);
  COV_STRONG_PULSE: cover property (@(posedge pclk) disable iff (!presetn)
    pullups.strong_pullup[0] ##1 !pullups.strong_pullup[0]);
  COV_SLVERR: cover property (@(posedge pclk) disable iff (!presetn) apb_rsp.pready && apb_rsp.pslverr);
endmodule
`default_nettype wire

// file: sim/ppl_pin_model.sv
// pin-side model: external drivers, pull-ups and released lines
`timescale 1ns/1ns
`default_nettype none
module ppl_pin_model (
  input wire logic pclk,
  input wire ppl_pkg::ppl_pin_drv_t drv,
  input wire ppl_pkg::ppl_pullup_t pu,
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  output logic [23:0] pin
);
  import ppl_pkg::*;
  logic flt = 1'b0;
  logic [9:0] pw;
  logic [23:0] oe;
  logic [23:0] dv;
  logic [23:0] up;
  // a line nobody holds must not keep its last level
  always @(posedge pclk) flt <= ~flt;
  assign pw = pu.strong_pullup | pu.keeper_pullup | pu.very_weak_pullup;
  assign oe = {drv.hi_oe, drv.mx_oe, drv.lo_oe};
  assign dv = {drv.hi_out, drv.mx_out, drv.lo_out};
  assign up = {pw[9:2], 6'h00, pw[1:0], 8'h00};
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin[i] = oe[i] ? dv[i] : ext_en[i] ? ext_val[i] : up[i] ? 1'b1 : flt;
    end
  end
endmodule
`default_nettype wire

// file: sim/test_ppl_port_latches.sv
// self-checking bench for the parallel port latches
`timescale 1ns/1ns
`default_nettype none
`include "ppl_cfg.svh"
module test_ppl_port_latches;
  import ppl_pkg::*;
  localparam int SC = 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  ppl_apb_req_t rq = '0;
  ppl_apb_rsp_t rs;
  ppl_xmem_t xm = '0;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic [23:0] ee = '0;
  logic [23:0] ev = '0;
  logic [23:0] pin;
  ppl_pin_drv_t dr;
  ppl_pullup_t pu;
  logic tc;
  logic tt;
  logic [5:0] an;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int lat[3] = '{255, 255, 255};
  int n;
  logic [31:0] rd;
  logic er;
  always #20 pclk = ~pclk;
  ppl_port_latches #(.STRONG_CYC(SC)) uut (.pclk(pclk), .presetn(presetn), .apb_req(rq), .apb_rsp(rs),
    .xmem(xm), .pwm_out_a(pa), .pwm_out_b(pb), .lo_pin_i(pin[7:0]), .mx_pin_i(pin[15:8]),
    .hi_pin_i(pin[23:16]), .pin_drv(dr), .pullups(pu), .timer_two_count_input(tc),
    .timer_two_trigger_input(tt), .analog_sel(an));
  ppl_pin_model pm (.pclk(pclk), .drv(dr), .pu(pu), .ext_en(ee), .ext_val(ev), .pin(pin));
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // entered just after a rising edge; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    rq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    rq.penable <= 1'b1;
    do @(posedge pclk); while (rs.pready !== 1'b1 && ++k < 20);
    if (k >= 20) begin
      failures++;
      $display("CHECK FAILED apb pready expected 1 seen 0");
    end
    rd = rs.prdata;
    er = rs.pslverr;
    rq.psel <= 1'b0;
    rq.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wl(input int i, input int d);
    lat[i] = d & 255;
    apb(1'b1, 8'(4 * i), 32'(d & 255));
  endtask
  initial begin
    void'($urandom(38559));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), '0);
      chk("latch reset", 32'hff, rd);
    end
    chk("weak pull", 32'h3ff, pu.very_weak_pullup);
    chk("analog sel", 32'h3f, an);
    $display("test reset done");
    for (int r = 0; r < 12; r++) begin
      wl(r % 3, $urandom);
      apb(1'b0, 8'(4 * (r % 3)), '0);
      chk("latch read", lat[r % 3], rd);
      @(posedge pclk);
      chk("lo oe", ~lat[0] & 255, dr.lo_oe);
      chk("lo out", 0, dr.lo_out);
      chk("mx oe", ~lat[1] & 3, dr.mx_oe);
      chk("analog", lat[1] >> 2, an);
      chk("hi oe", ~lat[2] & 255, dr.hi_oe);
    end
    $display("test latches done");
    for (int i = 0; i < 3; i++) wl(i, 255);
    ee <= 24'hffffff;
    ev <= 24'($urandom);
    repeat (5) @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(12 + 4 * i), '0);
      chk("pin read", (ev >> (8 * i)) & 255, rd);
    end
    ee <= '0;
    $display("test pin read done");
    wl(0, $urandom);
    wl(2, $urandom);
    xm <= '{active: 1'b1, ad_out: 8'($urandom), ad_oe: 1'b1, hi_en: 1'b1, addr_hi: 8'($urandom)};
    repeat (3) @(posedge pclk);
    chk("lo ad", xm.ad_out, dr.lo_out);
    chk("lo push", 32'hff, dr.lo_oe);
    chk("hi addr", xm.addr_hi, dr.hi_out);
    chk("hi push", 32'hff, dr.hi_oe);
    xm <= '0;
    repeat (2) @(posedge pclk);
    apb(1'b0, `PPL_OFF_LOW_LAT, '0);
    chk("lo forced", 32'hff, rd);
    apb(1'b0, `PPL_OFF_HI_LAT, '0);
    chk("hi kept", lat[2], rd);
    $display("test xmem done");
    wl(1, 0);
    apb(1'b1, `PPL_OFF_CTRL, 32'h1);
    for (int r = 0; r < 4; r++) begin
      pa <= 1'($urandom);
      pb <= 1'($urandom);
      repeat (3) @(posedge pclk);
      chk("pwm pins", {pb, pa}, dr.mx_out[1:0]);
    end
    apb(1'b1, `PPL_OFF_CTRL, 32'h0);
    $display("test pwm done");
    wl(1, 255);
    ee <= 24'h000300;
    ev <= 24'($urandom) & 24'h000300;
    repeat (5) @(posedge pclk);
    chk("t2 count", ev[8], tc);
    chk("t2 trig", ev[9], tt);
    ee <= '0;
    wl(1, 252);
    repeat (5) @(posedge pclk);
    chk("t2 off", 0, {tt, tc, dr.mx_out[1:0]});
    $display("test timer done");
    wl(1, 255);
    n = 0;
    repeat (8) begin
      @(posedge pclk);
      n += pu.strong_pullup[0];
    end
    chk("strong len", SC, n);
    chk("keeper on", 1, pu.keeper_pullup[0]);
    ee <= 24'h000100;
    ev <= '0;
    repeat (5) @(posedge pclk);
    chk("keeper off", 2'b01, {pu.keeper_pullup[0], pu.very_weak_pullup[0]});
    ee <= '0;
    apb(1'b0, 8'h1c, '0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    $display("test pull-up done");
    report_and_stop();
  end
endmodule
`default_nettype wire
